// [asp_defs.svh]
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
`define ASP_ONES_LAST 6'd31
`define ASP_SEL_COMM 3'h0
`define ASP_SEL_SETUP 3'h1
`define ASP_SEL_CLOCK 3'h2
`define ASP_SEL_DATA 3'h3
`define ASP_SEL_OFFSET 3'h4
`define ASP_SEL_GAIN 3'h5
`define ASP_CM_DIR 3
`define ASP_CM_SEL_HI 6
`define ASP_CM_SEL_LO 4
`define ASP_LEN_BYTE 5'd8
`define ASP_LEN_DATA 5'd16
`define ASP_LEN_WIDE 5'd24
`define ASP_RST_COMM 7'h00
`define ASP_RST_BYTE 8'h00
`define ASP_RST_WIDE 24'h000000
`define ASP_RST_DATA 16'h0000
`endif

// [asp_pkg.sv]
package asp_pkg;
	typedef enum logic [1:0] {ASP_IDLE, ASP_WR, ASP_RD} asp_ser_t;
	typedef enum logic {ASP_U_IDLE, ASP_U_HIGH} asp_upd_t;
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic din;
	} asp_pins_t;
endpackage

// [asp_port.sv]
`timescale 1ns/1ns
`include "asp_defs.svh"
// Summary of operation
// - after reset, first transfer writes communication register
// - communication byte selects direction and target register
// - data only via din/dout, timed by sclk
// - ready goes low when new result loaded
// - ready returns high after full result read
// - ready driven high before result register update
// - active-low chip select enables the port
// - result rereadable; host finishes before next update
// - cs tied low gives 3-wire, ready in comm msb
// - cs assertion presents msb; sclk may run
// - reset or 32 ones returns port idle
// - ones resync leaves register contents untouched, save comm when the 32nd one ends a comm byte
// - six registers, each reached via comm write
// - widths 8, result 16, offset/gain 24
// - selected transfer follows comm byte immediately
// - half duplex: no dout on write, din on read only feeds the ones count
// - all words travel msb first
module asp_port #(
	parameter int DEPTH = 2
) (
	// system
	input wire logic clock,
	input wire logic sys_rst,
	// serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	output logic result_ready_n,
	// conversion words in
	input wire logic in_valid,
	input wire logic [15:0] in_data,
	output logic in_ready,
	// register contents out
	output logic [7:0] setup_reg,
	output logic [7:0] clock_reg,
	output logic [23:0] offset_reg,
	output logic [23:0] gain_reg
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	function automatic logic [4:0] len_of(input logic [2:0] sel);
		if (sel == `ASP_SEL_DATA) begin
			len_of = `ASP_LEN_DATA;
		end else if (sel == `ASP_SEL_OFFSET || sel == `ASP_SEL_GAIN) begin
			len_of = `ASP_LEN_WIDE;
		end else begin
			len_of = `ASP_LEN_BYTE;
		end
	endfunction

	function automatic logic [PW-1:0] inc_ptr(input logic [PW-1:0] p);
		inc_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	asp_pkg::asp_pins_t s1, s2, s3;
	asp_pkg::asp_ser_t st, next_st;
	asp_pkg::asp_upd_t upd, next_upd;
	logic [4:0] cnt, next_cnt;
	logic [23:0] sh, next_sh;
	logic pend, next_pend;
	logic [5:0] ones, next_ones;
	logic [6:0] comm, next_comm;
	logic [7:0] next_setup, next_clock;
	logic [23:0] next_offset, next_gain;
	logic [15:0] data_reg, next_data_reg;
	logic next_rdy_n, next_dout, next_oe, next_in_ready;
	logic [15:0] mem [DEPTH];
	logic [PW-1:0] wp, next_wp, rp, next_rp;
	logic [CW-1:0] fill, next_fill;
	logic rise, fall, act, busy, push, pop;
	logic [2:0] sel;
	logic [23:0] wr_word;
	logic [7:0] cbyte;

	// pins cross into the clock domain; edges found on stage two
	assign rise = s2.sclk & ~s3.sclk;
	assign fall = ~s2.sclk & s3.sclk;
	assign act = ~s2.cs_n;
	assign sel = comm[`ASP_CM_SEL_HI:`ASP_CM_SEL_LO];
	assign wr_word = {sh[22:0], s2.din};
	assign cbyte = wr_word[7:0];

	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_sh = sh;
		next_pend = pend;
		next_ones = ones;
		next_comm = comm;
		next_setup = setup_reg;
		next_clock = clock_reg;
		next_offset = offset_reg;
		next_gain = gain_reg;
		next_data_reg = data_reg;
		next_rdy_n = result_ready_n;
		next_upd = upd;
		next_wp = wp;
		next_rp = rp;
		next_fill = fill;
		pop = 1'b0;
		// clocks while deselected are ignored entirely
		if (rise && act) begin
			next_ones = s2.din ? ones + 6'd1 : 6'd0;
			case (st)
				asp_pkg::ASP_IDLE: begin
					next_sh = wr_word;
					next_cnt = cnt + 5'd1;
					if (cnt == `ASP_LEN_BYTE - 5'd1) begin
						next_comm = cbyte[6:0];
						next_cnt = 5'd0;
						next_pend = 1'b0;
						// the next transfer starts on the very next clock
						if (cbyte[`ASP_CM_DIR]) begin
							next_st = asp_pkg::ASP_RD;
							case (cbyte[`ASP_CM_SEL_HI:`ASP_CM_SEL_LO])
								`ASP_SEL_COMM: next_sh = {result_ready_n, comm, 16'h0000};
								`ASP_SEL_SETUP: next_sh = {setup_reg, 16'h0000};
								`ASP_SEL_CLOCK: next_sh = {clock_reg, 16'h0000};
								`ASP_SEL_DATA: next_sh = {data_reg, 8'h00};
								`ASP_SEL_OFFSET: next_sh = offset_reg;
								`ASP_SEL_GAIN: next_sh = gain_reg;
								default: next_sh = 24'h000000;
							endcase
						end else if (cbyte[`ASP_CM_SEL_HI:`ASP_CM_SEL_LO] != `ASP_SEL_COMM) begin
							next_st = asp_pkg::ASP_WR;
						end
					end
				end
				asp_pkg::ASP_WR: begin
					next_sh = wr_word;
					next_cnt = cnt + 5'd1;
					if (cnt == len_of(sel) - 5'd1) begin
						next_st = asp_pkg::ASP_IDLE;
						next_cnt = 5'd0;
						// result register is read-only; a write to it is dropped
						if (sel == `ASP_SEL_SETUP) begin
							next_setup = wr_word[7:0];
						end else if (sel == `ASP_SEL_CLOCK) begin
							next_clock = wr_word[7:0];
						end else if (sel == `ASP_SEL_OFFSET) begin
							next_offset = wr_word;
						end else if (sel == `ASP_SEL_GAIN) begin
							next_gain = wr_word;
						end
					end
				end
				default: begin
					next_cnt = cnt + 5'd1;
					next_pend = 1'b1;
					if (cnt == len_of(sel) - 5'd1) begin
						next_st = asp_pkg::ASP_IDLE;
						next_cnt = 5'd0;
						next_pend = 1'b0;
						if (sel == `ASP_SEL_DATA) begin
							next_rdy_n = 1'b1;
						end
					end
				end
			endcase
			// resync wins over any transfer; registers stay as they are, except comm when the 32nd one completes a comm byte
			if (s2.din && ones == `ASP_ONES_LAST) begin
				next_st = asp_pkg::ASP_IDLE;
				next_cnt = 5'd0;
				next_pend = 1'b0;
				next_ones = 6'd0;
			end
		end
		// msb stays put until the host has sampled it once
		if (fall && act && st == asp_pkg::ASP_RD && pend) begin
			next_sh = {sh[22:0], 1'b0};
			next_pend = 1'b0;
		end
		push = in_valid && in_ready;
		// an unread or in-flight result stalls the update, so the buffer backs up
		busy = !result_ready_n
			|| (next_st == asp_pkg::ASP_RD
			&& next_comm[`ASP_CM_SEL_HI:`ASP_CM_SEL_LO] == `ASP_SEL_DATA);
		case (upd)
			asp_pkg::ASP_U_IDLE: begin
				if (fill != '0 && !busy) begin
					next_rdy_n = 1'b1;
					next_upd = asp_pkg::ASP_U_HIGH;
				end
			end
			default: begin
				next_data_reg = mem[rp];
				next_rdy_n = 1'b0;
				pop = 1'b1;
				next_upd = asp_pkg::ASP_U_IDLE;
			end
		endcase
		if (push) begin
			next_wp = inc_ptr(wp);
		end
		if (pop) begin
			next_rp = inc_ptr(rp);
		end
		next_fill = fill + CW'(push) - CW'(pop);
		next_in_ready = next_fill != CW'(DEPTH);
		next_oe = next_st == asp_pkg::ASP_RD && ~s2.cs_n;
		// shifter echoes din outside reads, so the pin is held at zero then
		next_dout = next_oe && next_sh[23];
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s1 <= '1;
			s2 <= '1;
			s3 <= '1;
			st <= asp_pkg::ASP_IDLE;
			upd <= asp_pkg::ASP_U_IDLE;
			cnt <= 5'd0;
			sh <= 24'h000000;
			pend <= 1'b0;
			ones <= 6'd0;
			comm <= `ASP_RST_COMM;
			setup_reg <= `ASP_RST_BYTE;
			clock_reg <= `ASP_RST_BYTE;
			offset_reg <= `ASP_RST_WIDE;
			gain_reg <= `ASP_RST_WIDE;
			data_reg <= `ASP_RST_DATA;
			result_ready_n <= 1'b1;
			dout <= 1'b0;
			dout_oe <= 1'b0;
			wp <= '0;
			rp <= '0;
			fill <= '0;
			in_ready <= 1'b0;
		end else begin
			s1 <= {sclk, cs_n, din};
			s2 <= s1;
			s3 <= s2;
			st <= next_st;
			upd <= next_upd;
			cnt <= next_cnt;
			sh <= next_sh;
			pend <= next_pend;
			ones <= next_ones;
			comm <= next_comm;
			setup_reg <= next_setup;
			clock_reg <= next_clock;
			offset_reg <= next_offset;
			gain_reg <= next_gain;
			data_reg <= next_data_reg;
			result_ready_n <= next_rdy_n;
			dout <= next_dout;
			dout_oe <= next_oe;
			wp <= next_wp;
			rp <= next_rp;
			fill <= next_fill;
			in_ready <= next_in_ready;
		end
	end

	// buffer storage carries no reset
	always_ff @(posedge clock) begin
		if (in_valid && in_ready) begin
			mem[wp] <= in_data;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	a_load_drives_low: assert property (upd == asp_pkg::ASP_U_HIGH |=> !result_ready_n)
		else $error("ready not low after load");
	a_high_before_load: assert property ($changed(data_reg) |-> $past(result_ready_n, 1))
		else $error("result changed while ready low");
	a_read_done_high: assert property (rise && act && st == asp_pkg::ASP_RD
		&& sel == `ASP_SEL_DATA && cnt == 5'd15 |=> result_ready_n)
		else $error("ready not high after result read");
	a_ones_resync: assert property (rise && act && s2.din && ones == 6'd31
		|=> st == asp_pkg::ASP_IDLE && cnt == 5'd0)
		else $error("32 ones did not resync");
	a_resync_keeps: assert property (rise && act && s2.din && ones == 6'd31
		|=> $stable(setup_reg) && $stable(gain_reg) && $stable(offset_reg))
		else $error("resync changed a register");
	a_comm_dir: assert property (rise && act && st == asp_pkg::ASP_IDLE && cnt == 5'd7
		&& ones != 6'd31 && sh[2] |=> st == asp_pkg::ASP_RD ##0 dout_oe)
		else $error("read direction not taken");
	a_half_duplex: assert property (dout_oe |-> st == asp_pkg::ASP_RD)
		else $error("dout driven outside read");
	a_quiet_on_write: assert property (!dout_oe |-> !dout)
		else $error("dout shows data outside read");
	a_cs_gates: assert property (s2.cs_n |=> $stable(cnt) && !dout_oe)
		else $error("port active while deselected");
	a_msb_first: assert property (dout_oe |-> dout == sh[23])
		else $error("dout not msb of shifter");

	c_result_read: cover property (rise && act && st == asp_pkg::ASP_RD && sel == `ASP_SEL_DATA);
	c_wide_write: cover property (st == asp_pkg::ASP_WR && sel == `ASP_SEL_GAIN && cnt == 5'd23);
	c_resync: cover property (rise && act && s2.din && ones == 6'd31);
	c_buffer_full: cover property (!in_ready && fill == CW'(DEPTH));
endmodule

// [asp_host.sv]
`timescale 1ns/1ns
module asp_host (
	// serial pins
	output asp_pkg::asp_pins_t pins,
	// data back from the device
	input wire logic dout
);
	initial begin
		pins = '{sclk: 1'b1, cs_n: 1'b1, din: 1'b1};
	end
	// phase lengths that are not multiples of five keep pin edges off the system clock edges
	task automatic frame(input int n, input logic [31:0] w, output logic [31:0] r);
		r = '0;
		#2 pins.cs_n = 1'b0;
		#64;
		for (int i = n - 1; i >= 0; i--) begin
			pins.sclk = 1'b0;
			pins.din = w[i];
			#61 r = {r[30:0], dout};
			pins.sclk = 1'b1;
			#64;
		end
		pins.cs_n = 1'b1;
		// released line shows the inverse, not a stale copy
		pins.din = ~pins.din;
		#200;
	endtask
endmodule

// [test_asp_port.sv]
`timescale 1ns/1ns
`include "asp_defs.svh"
module test_asp_port;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic in_valid = 1'b0;
	logic [15:0] in_data = 16'h0000;
	asp_pkg::asp_pins_t pins;
	logic dout, dout_oe, result_ready_n, in_ready;
	logic [7:0] setup_reg, clock_reg;
	logic [23:0] offset_reg, gain_reg;
	logic [31:0] rd;
	logic [2:0] sel [4] = '{`ASP_SEL_SETUP, `ASP_SEL_CLOCK, `ASP_SEL_OFFSET, `ASP_SEL_GAIN};
	int wid [4] = '{8, 8, 24, 24};
	logic [23:0] val [4] = '{24'h0000a5, 24'h00005c, 24'h123456, 24'habcdef};
	int error_cnt = 0;
	int tests_run = 0;
	initial begin
		forever #5 clock = ~clock;
	end
	asp_port DUT (.clock(clock), .sys_rst(sys_rst), .sclk(pins.sclk), .cs_n(pins.cs_n),
		.din(pins.din), .dout(dout), .dout_oe(dout_oe), .result_ready_n(result_ready_n),
		.in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .setup_reg(setup_reg),
		.clock_reg(clock_reg), .offset_reg(offset_reg), .gain_reg(gain_reg));
	asp_host host (.pins(pins), .dout(dout));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic xfer(input int n, input logic [31:0] w);
		@(negedge clock);
		host.frame(n, w, rd);
	endtask
	task automatic wait_low();
		int k;
		for (k = 0; k < 400 && result_ready_n !== 1'b0; k++) @(negedge clock);
		if (k == 400) begin
			error_cnt++;
			conclude();
		end
	endtask
	// in_valid stays up between pushes so back to back words need no gap
	task automatic push(input logic [15:0] w);
		int k;
		in_valid = 1'b1;
		in_data = w;
		// in_ready is settled at the falling edge; the next rise takes the word
		for (k = 0; k < 400 && in_ready !== 1'b1; k++) @(negedge clock);
		if (k == 400) begin
			error_cnt++;
			conclude();
		end
		@(negedge clock);
	endtask
	task automatic rd_result(input logic [15:0] exp);
		wait_low();
		xfer(24, 32'h00380000);
		check(rd, {16'h0000, exp});
	endtask
	initial begin
		repeat (3) @(posedge clock);
		@(negedge clock);
		check({result_ready_n, dout_oe, in_ready}, 3'b100);
		sys_rst = 1'b0;
		repeat (4) @(negedge clock);
		check(in_ready, 1'b1);
		check({setup_reg, clock_reg}, 16'h0000);
		check(offset_reg, 24'h000000);
		check(gain_reg, 24'h000000);
		for (int i = 0; i < 4; i++) begin
			xfer(8 + wid[i], ({24'h0, 1'b0, sel[i], 4'h0} << wid[i]) | val[i]);
		end
		check({setup_reg, clock_reg}, 16'ha55c);
		check(offset_reg, 24'h123456);
		check(gain_reg, 24'habcdef);
		for (int i = 0; i < 4; i++) begin
			xfer(8 + wid[i], {24'h0, 1'b0, sel[i], 4'h8} << wid[i]);
			check(rd, {8'h00, val[i]});
		end
		// misaligned half byte, then the ones resync
		xfer(4, 32'h0);
		xfer(32, 32'hffffffff);
		check({setup_reg, gain_reg}, 32'ha5abcdef);
		xfer(16, 32'h0000103c);
		check(setup_reg, 8'h3c);
		// comm and data in two frames: chip select alone brings the msb out
		xfer(8, 32'h00000018);
		xfer(8, 32'h00000000);
		check(rd, 32'h0000003c);
		@(negedge clock);
		push(16'h1234);
		push(16'hbeef);
		push(16'h0f0f);
		in_data = 16'h5a5a;
		repeat (10) @(negedge clock);
		check(in_ready, 1'b0);
		xfer(16, 32'h00000800);
		check(rd[7], 1'b0);
		rd_result(16'h1234);
		// the held word went in as soon as the read freed a slot
		@(negedge clock);
		in_valid = 1'b0;
		check(in_ready, 1'b0);
		xfer(24, 32'h0030ffff);
		rd_result(16'hbeef);
		rd_result(16'h0f0f);
		rd_result(16'h5a5a);
		repeat (10) @(negedge clock);
		check(result_ready_n, 1'b1);
		xfer(24, 32'h00380000);
		check(rd, 32'h00005a5a);
		conclude();
	end
endmodule
